// File: rtl/pcst_pkg.sv
package pcst_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word addresses on the parameter port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CAP0_FLAG    = 8'h4a;
  localparam logic [7:0] OFS_CAP0_TSTAMP  = 8'h4c;
  localparam logic [7:0] OFS_CAP0_TRIGSEL = 8'h4e;
  localparam logic [7:0] OFS_CAP1_FLAG    = 8'h64;
  localparam logic [7:0] OFS_CAP1_TSTAMP  = 8'h66;
  localparam logic [7:0] OFS_CAP1_TRIGSEL = 8'h68;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         FLAG_BIT         = 0;
  localparam logic [7:0] RST_TRIGSEL      = 8'h00;
  localparam logic [7:0] TRIGSEL_MAX      = 8'h0b;
  localparam logic       RST_FLAG         = 1'b0;
  localparam logic [31:0] RST_TSTAMP      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Trigger source codes
  // ----------------------------------------------------------------
  localparam int         NUM_TRIG         = 12;
  localparam int         NUM_DIN          = 7;
  localparam int         NUM_DIFF         = 3;
  localparam logic [7:0] TRIG_DIFF_FIRST  = 8'h07;
  localparam logic [7:0] TRIG_IDX_PRI     = 8'h0a;
  localparam logic [7:0] TRIG_IDX_TER     = 8'h0b;

  // ----------------------------------------------------------------
  // Edge selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_RESERVED    = 2'h0;
  localparam logic [1:0] EDGE_RISING      = 2'h1;
  localparam logic [1:0] EDGE_FALLING     = 2'h2;
  localparam logic [1:0] EDGE_BOTH        = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          SYNC_PERIOD_NS  = 62500;
  localparam int          SYNC_CYCLES     = SYNC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] SYNC_LAST       = 12'(SYNC_CYCLES - 1);
  localparam logic [31:0] NS_STEP         = 32'(CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Channel carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       time_mode;
    logic [1:0] edge_sel;
    logic [7:0] trig_sel;
  } pcst_chan_cfg_t;

  typedef struct packed {
    logic        captured;
    logic [31:0] timestamp;
  } pcst_chan_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_DONE  = 3'b100
  } pcst_state_t;

endpackage

// File: rtl/pcst_channel.sv
`timescale 1ns/1ns
module pcst_channel (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire pcst_pkg::pcst_chan_cfg_t  cfg,
  input  wire logic [11:0]               trig_vec,
  input  wire logic [31:0]               ts_now,
  output pcst_pkg::pcst_chan_stat_t      stat
);

  // ----------------------------------------------------------------
  // Trigger selection and edge detection
  // ----------------------------------------------------------------
  logic                  en_prev;
  logic                  trig_prev;
  pcst_pkg::pcst_state_t state;
  pcst_pkg::pcst_state_t next_state;
  logic [31:0]           tstamp;
  logic [31:0]           next_tstamp;

  wire sel_ok    = cfg.trig_sel <= pcst_pkg::TRIGSEL_MAX;
  wire trig_lvl  = sel_ok ? trig_vec[cfg.trig_sel[3:0]] : 1'b0;
  wire rise      = trig_lvl & ~trig_prev;
  wire fall      = ~trig_lvl & trig_prev;
  // Edge only, never level; reserved code never fires
  wire edge_hit  = (cfg.edge_sel == pcst_pkg::EDGE_RISING  && rise) ||
                   (cfg.edge_sel == pcst_pkg::EDGE_FALLING && fall) ||
                   (cfg.edge_sel == pcst_pkg::EDGE_BOTH    && (rise || fall)); // [RL7]
  wire en_rise   = cfg.enable & ~en_prev;

  // ----------------------------------------------------------------
  // Arm / capture sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_tstamp = tstamp;
    case (state)
      pcst_pkg::ST_IDLE: begin
        if (en_rise) begin
          next_state = pcst_pkg::ST_ARMED; // [RL1]
        end
      end
      pcst_pkg::ST_ARMED: begin
        if (!cfg.enable) begin
          next_state = pcst_pkg::ST_IDLE;
        end else if (edge_hit) begin
          next_state = pcst_pkg::ST_DONE; // [RL8]
          if (cfg.time_mode) begin
            next_tstamp = ts_now; // [RL3]
          end
        end
      end
      pcst_pkg::ST_DONE: begin
        if (!cfg.enable) begin
          next_state = pcst_pkg::ST_IDLE; // [RL2]
        end
      end
      default: next_state = pcst_pkg::ST_IDLE;
    endcase
  end

  // State, history and result registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= pcst_pkg::ST_IDLE;
      en_prev   <= 1'b0;
      trig_prev <= 1'b0;
      tstamp    <= pcst_pkg::RST_TSTAMP;
    end else begin
      state     <= next_state;
      en_prev   <= cfg.enable;
      trig_prev <= trig_lvl;
      tstamp    <= next_tstamp;
    end
  end

  // Flag is high only in the captured state; one driver for the whole struct
  assign stat = {state == pcst_pkg::ST_DONE, tstamp}; // [RL2]

endmodule

// File: rtl/pcst_top.sv
`timescale 1ns/1ns
// What this block does
// RL1 - Enabling a channel clears its captured flag until the next capture.
// RL2 - Captured flag reads 1 after capture, 0 otherwise or disabled, resets 0.
// RL3 - Timestamp is stored only when the channel is in time capture mode.
// RL4 - Timestamp is unsigned 32-bit nanoseconds since last 62.5 us sync pulse.
// RL5 - Each channel has an 8-bit trigger selector, legal 0 to 11, default 0.
// RL6 - Codes 0-6 digital inputs, 7-9 differential inputs, 10 primary, 11 tertiary index.
// RL7 - Trigger is edge detected: 1 rising, 2 falling, 3 both, 0 reserved.
// RL8 - First qualifying edge after enabling latches; later edges ignored until re-enable.
module pcst_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [6:0]  digital_in,
  input  wire logic [2:0]  diff_in,
  input  wire logic        index_primary,
  input  wire logic        index_tertiary,
  input  wire logic        capture0_enable,
  input  wire logic        capture0_mode,
  input  wire logic [1:0]  capture0_edge,
  input  wire logic        capture1_enable,
  input  wire logic        capture1_mode,
  input  wire logic [1:0]  capture1_edge,
  output logic             periodic_sync_pulse
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] pins_raw;
  logic [11:0] pins_meta;
  logic [11:0] trig_vec;
  logic [1:0]  ctl_meta0;
  logic [1:0]  ctl_sync0;
  logic [1:0]  ctl_meta1;
  logic [1:0]  ctl_sync1;

  // Source order matches the selector codes
  assign pins_raw = {index_tertiary, index_primary, diff_in, digital_in}; // [RL6]

  // Two flip-flops per trigger input
  genvar gi;
  generate
    for (gi = 0; gi < pcst_pkg::NUM_TRIG; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pins_meta[gi] <= 1'b0;
          trig_vec[gi]  <= 1'b0;
        end else begin
          pins_meta[gi] <= pins_raw[gi];
          trig_vec[gi]  <= pins_meta[gi];
        end
      end
    end
  endgenerate

  // Control levels from outside also pass two flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_meta0 <= 2'h0;
      ctl_sync0 <= 2'h0;
      ctl_meta1 <= 2'h0;
      ctl_sync1 <= 2'h0;
    end else begin
      ctl_meta0 <= {capture0_enable, capture0_mode};
      ctl_sync0 <= ctl_meta0;
      ctl_meta1 <= {capture1_enable, capture1_mode};
      ctl_sync1 <= ctl_meta1;
    end
  end

  logic [1:0] edge_meta0;
  logic [1:0] edge_sync0;
  logic [1:0] edge_meta1;
  logic [1:0] edge_sync1;

  // Edge selections, same treatment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_meta0 <= pcst_pkg::EDGE_RESERVED;
      edge_sync0 <= pcst_pkg::EDGE_RESERVED;
      edge_meta1 <= pcst_pkg::EDGE_RESERVED;
      edge_sync1 <= pcst_pkg::EDGE_RESERVED;
    end else begin
      edge_meta0 <= capture0_edge;
      edge_sync0 <= edge_meta0;
      edge_meta1 <= capture1_edge;
      edge_sync1 <= edge_meta1;
    end
  end

  // ----------------------------------------------------------------
  // Sync pulse and nanosecond time base
  // ----------------------------------------------------------------
  logic [11:0] sync_cnt;
  logic [31:0] ns_time;

  wire sync_wrap = sync_cnt == pcst_pkg::SYNC_LAST;

  // Time restarts from zero at every sync pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_cnt            <= 12'h000;
      ns_time             <= 32'h0000_0000;
      periodic_sync_pulse <= 1'b0;
    end else begin
      sync_cnt            <= sync_wrap ? 12'h000 : sync_cnt + 12'h001;
      ns_time             <= sync_wrap ? 32'h0000_0000 : ns_time + pcst_pkg::NS_STEP; // [RL4]
      periodic_sync_pulse <= sync_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Trigger source selectors
  // ----------------------------------------------------------------
  logic [7:0] capture0_trigger_source_select;
  logic [7:0] capture1_trigger_source_select;

  wire wdata_legal = reg_wdata[31:8] == 24'h000000 &&
                     reg_wdata[7:0] <= pcst_pkg::TRIGSEL_MAX;
  wire wr_sel0     = reg_wr && reg_addr == pcst_pkg::OFS_CAP0_TRIGSEL && wdata_legal;
  wire wr_sel1     = reg_wr && reg_addr == pcst_pkg::OFS_CAP1_TRIGSEL && wdata_legal;

  // Out-of-range codes are dropped, old value kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture0_trigger_source_select <= pcst_pkg::RST_TRIGSEL; // [RL5]
      capture1_trigger_source_select <= pcst_pkg::RST_TRIGSEL; // [RL5]
    end else begin
      if (wr_sel0) begin
        capture0_trigger_source_select <= reg_wdata[7:0]; // [RL5]
      end
      if (wr_sel1) begin
        capture1_trigger_source_select <= reg_wdata[7:0]; // [RL5]
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  pcst_pkg::pcst_chan_cfg_t  cfg0;
  pcst_pkg::pcst_chan_cfg_t  cfg1;
  pcst_pkg::pcst_chan_stat_t stat0;
  pcst_pkg::pcst_chan_stat_t stat1;

  // Gather per-channel configuration
  assign cfg0 = {ctl_sync0[1], ctl_sync0[0], edge_sync0, capture0_trigger_source_select};
  assign cfg1 = {ctl_sync1[1], ctl_sync1[0], edge_sync1, capture1_trigger_source_select};

  pcst_channel u_chan0 (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cfg      (cfg0),
    .trig_vec (trig_vec),
    .ts_now   (ns_time),
    .stat     (stat0)
  );

  pcst_channel u_chan1 (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cfg      (cfg1),
    .trig_vec (trig_vec),
    .ts_now   (ns_time),
    .stat     (stat1)
  );

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] next_rd_data;

  wire [31:0] flag0_word = {31'h0, stat0.captured}; // [RL2]
  wire [31:0] flag1_word = {31'h0, stat1.captured}; // [RL2]
  wire [31:0] sel0_word  = {24'h000000, capture0_trigger_source_select};
  wire [31:0] sel1_word  = {24'h000000, capture1_trigger_source_select};

  // Address decode; unmapped addresses read zero
  assign next_rd_data =
    (reg_addr == pcst_pkg::OFS_CAP0_FLAG)    ? flag0_word      :
    (reg_addr == pcst_pkg::OFS_CAP0_TSTAMP)  ? stat0.timestamp :
    (reg_addr == pcst_pkg::OFS_CAP0_TRIGSEL) ? sel0_word       :
    (reg_addr == pcst_pkg::OFS_CAP1_FLAG)    ? flag1_word      :
    (reg_addr == pcst_pkg::OFS_CAP1_TSTAMP)  ? stat1.timestamp :
    (reg_addr == pcst_pkg::OFS_CAP1_TRIGSEL) ? sel1_word       :
    32'h0000_0000;

  // Read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? next_rd_data : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

endmodule

// File: testbench/pcst_checker.sv
`timescale 1ns/1ns
module pcst_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        capture0_enable,
  input wire logic        capture1_enable,
  input wire logic        periodic_sync_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------
  // Read decode and sync spacing
  // ----------------------------
  logic [12:0] gap;
  logic        seen;
  wire rd_f0 = reg_rd && reg_addr == pcst_pkg::OFS_CAP0_FLAG;
  wire rd_f1 = reg_rd && reg_addr == pcst_pkg::OFS_CAP1_FLAG;
  wire rd_ts = reg_rd && (reg_addr == pcst_pkg::OFS_CAP0_TSTAMP
    || reg_addr == pcst_pkg::OFS_CAP1_TSTAMP);
  wire rd_sl = reg_rd && (reg_addr == pcst_pkg::OFS_CAP0_TRIGSEL
    || reg_addr == pcst_pkg::OFS_CAP1_TRIGSEL);
  // Cycles since the last sync pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap  <= 13'h0000;
      seen <= 1'b0;
    end else begin
      gap  <= periodic_sync_pulse ? 13'h0001 : gap + 13'h0001;
      seen <= seen | periodic_sync_pulse;
    end
  end
  sequence s_off0; !capture0_enable [*6] ##0 rd_f0; endsequence
  sequence s_off1; !capture1_enable [*6] ##0 rd_f1; endsequence
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  property p_bits; rd_f0 || rd_f1 |=> reg_rdata[31:1] == 31'h0; endproperty
  property p_off0; s_off0 |=> reg_rdata == 32'h0; endproperty
  property p_off1; s_off1 |=> reg_rdata == 32'h0; endproperty
  property p_sel; rd_sl |=> reg_rdata <= 32'h0000000b; endproperty
  property p_ts; rd_ts |=> reg_rdata < 32'h0000f424; endproperty
  property p_step; rd_ts |=> reg_rdata % 32'h14 == 32'h0; endproperty
  property p_sync; seen |-> periodic_sync_pulse == (gap == 13'h0c35); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_bits: assert property (p_bits) else $error("flag word has extra bits");
  a_off0: assert property (p_off0) else $error("flag 0 set while off");
  a_off1: assert property (p_off1) else $error("flag 1 set while off");
  a_sel: assert property (p_sel) else $error("selector out of range");
  a_ts: assert property (p_ts) else $error("timestamp beyond sync period");
  a_step: assert property (p_step) else $error("timestamp not in clock steps");
  a_sync: assert property (p_sync) else $error("sync pulse spacing wrong");
endmodule
bind pcst_top pcst_checker u_chk (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
  .reg_rvalid, .capture0_enable, .capture1_enable, .periodic_sync_pulse);

// File: testbench/pcst_trig_model.sv
`timescale 1ns/1ns
module pcst_trig_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sel,
  input  wire logic       lvl,
  output logic [6:0]      digital_in,
  output logic [2:0]      diff_in,
  output logic            index_primary,
  output logic            index_tertiary
);
  logic [11:0] lines;
  // Selected source follows the level, the rest keep their last value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lines <= 12'h000;
    end else if (sel < 8'h0c) begin
      lines[sel[3:0]] <= lvl;
    end
  end
  // Fan out to the input groups
  assign digital_in     = lines[6:0];
  assign diff_in        = lines[9:7];
  assign index_primary  = lines[10];
  assign index_tertiary = lines[11];
endmodule

// File: testbench/tb_position_capture_status_timestamp.sv
`timescale 1ns/1ns
module tb_position_capture_status_timestamp;
  localparam logic [7:0] F0 = pcst_pkg::OFS_CAP0_FLAG;
  localparam logic [7:0] F1 = pcst_pkg::OFS_CAP1_FLAG;
  localparam logic [7:0] T0 = pcst_pkg::OFS_CAP0_TSTAMP;
  localparam logic [7:0] T1 = pcst_pkg::OFS_CAP1_TSTAMP;
  localparam logic [7:0] S0 = pcst_pkg::OFS_CAP0_TRIGSEL;
  localparam logic [7:0] S1 = pcst_pkg::OFS_CAP1_TRIGSEL;
  logic        clk, sys_rst, reg_wr, reg_rd, reg_rvalid, src_lvl;
  logic [7:0]  reg_addr, src_sel;
  logic [31:0] reg_wdata, reg_rdata, ts_a;
  logic [6:0]  digital_in;
  logic [2:0]  diff_in;
  logic        index_primary, index_tertiary, periodic_sync_pulse;
  logic        capture0_enable, capture0_mode, capture1_enable, capture1_mode;
  logic [1:0]  capture0_edge, capture1_edge;
  int          mismatches;
  int          checks_done;
  time         t_sync;
  pcst_top uut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .digital_in, .diff_in, .index_primary, .index_tertiary, .capture0_enable,
    .capture0_mode, .capture0_edge, .capture1_enable, .capture1_mode, .capture1_edge,
    .periodic_sync_pulse);
  pcst_trig_model src (.clk, .sys_rst, .sel(src_sel), .lvl(src_lvl), .digital_in,
    .diff_in, .index_primary, .index_tertiary);
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  // Drive one source line and let the capture path settle
  task automatic line(input logic [7:0] s, input logic l);
    @(posedge clk);
    src_sel <= s;
    src_lvl <= l;
    repeat (8) @(posedge clk);
  endtask
  task automatic arm(input logic [1:0] e0, input logic [1:0] e1, input logic on);
    @(posedge clk);
    capture0_enable <= 1'b0;
    capture1_enable <= 1'b0;
    capture0_edge   <= e0;
    capture1_edge   <= e1;
    repeat (6) @(posedge clk);
    capture0_enable <= on;
    capture1_enable <= on;
    repeat (6) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------
  // Clock, tests
  // ------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("wrong value at %0t ns: run did not finish", $time);
    tally_and_finish;
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, src_lvl, capture0_enable, capture1_enable} = 6'h21;
    {reg_addr, src_sel, reg_wdata} = 48'h0;
    {capture0_mode, capture1_mode, capture0_edge, capture1_edge} = 6'h25;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(F0, 32'h0);
    rdchk(F1, 32'h0);
    rdchk(S0, 32'h0);
    rdchk(S1, 32'h0);
    $display("test reset values done");
    for (int c = 0; c < 13; c++) begin
      wr(S0, 32'(c));
      rdchk(S0, c < 12 ? 32'(c) : 32'h0000000b);
    end
    wr(S1, 32'h00000103);
    rdchk(S1, 32'h0);
    $display("test selector range done");
    for (int c = 0; c < 12; c++) begin
      wr(S0, 32'(c));
      wr(S1, 32'(c));
      line(8'(c), 1'b0);
      arm(pcst_pkg::EDGE_RISING, pcst_pkg::EDGE_FALLING, 1'b1);
      rdchk(F0, 32'h0);
      line(8'(c), 1'b1);
      rdchk(F0, 32'h1);
      rdchk(F1, 32'h0);
      rd(T0, ts_a);
      chk({31'h0, ts_a < 32'd62500 && ts_a % 32'd20 == 32'h0}, 32'h1);
      line(8'(c), 1'b0);
      rdchk(F1, 32'h1);
      rdchk(T0, ts_a);
      rdchk(T1, 32'h0);
    end
    $display("test trigger sources done");
    wr(S0, 32'h0000000a);
    wr(S1, 32'h0000000a);
    arm(pcst_pkg::EDGE_BOTH, pcst_pkg::EDGE_RESERVED, 1'b1);
    line(8'h0a, 1'b1);
    rd(T0, ts_a);
    line(8'h0a, 1'b0);
    rdchk(T0, ts_a);
    rdchk(F0, 32'h1);
    rdchk(F1, 32'h0);
    arm(pcst_pkg::EDGE_BOTH, pcst_pkg::EDGE_RISING, 1'b0);
    rdchk(F0, 32'h0);
    rdchk(F1, 32'h0);
    arm(pcst_pkg::EDGE_BOTH, pcst_pkg::EDGE_RISING, 1'b1);
    rdchk(F0, 32'h0);
    $display("test edges and rearm done");
    // Pin set one clock after the pulse: model, two syncs, compare, capture
    @(posedge clk iff periodic_sync_pulse);
    t_sync = $time;
    line(8'h0a, 1'b1);
    rdchk(F0, 32'h1);
    rdchk(T0, 32'(5 * pcst_pkg::CLK_PERIOD_NS));
    // Spacing of two sync pulses in clocks
    @(posedge clk iff periodic_sync_pulse);
    chk(32'(($time - t_sync) / pcst_pkg::CLK_PERIOD_NS), 32'(pcst_pkg::SYNC_CYCLES));
    $display("test sync reference done");
    tally_and_finish;
  end
endmodule
